/* dv/dirq_controller_checker.sv */
module dirq_checker #(parameter NPIN = 6, parameter NSUB_MAIN = 4, parameter NSUB_SECOND = 4) (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [NSUB_MAIN-1:0] short_main_sub,
  input wire [NSUB_SECOND-1:0] short_second_sub,
  input wire [1:0] excess_sub,
  input wire mixer_drop,
  input wire [2:0] port_error,
  input wire jack_sense_one,
  input wire [NPIN-1:0] gpio_in,
  input wire [1:0] core_processor_flags,
  input wire request_line_a_pin,
  input wire request_line_b,
  input wire [NPIN-1:0] gpio_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EW = NSUB_MAIN + NSUB_SECOND + NPIN + 9;
  wire take = clk_en && hsel && hready && htrans[1];
  wire [EW-1:0] ev = {short_main_sub, short_second_sub, excess_sub, mixer_drop, port_error, jack_sense_one, gpio_in,
    core_processor_flags};
  logic [EW-1:0] ev_reg;
  logic [4:0] quiet_reg;
  logic written_reg;
  // Counts cycles since the last input change or bus transfer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_reg <= '0;
      quiet_reg <= 5'h0;
      written_reg <= 1'b0;
    end else begin
      ev_reg <= ev;
      written_reg <= written_reg || (take && hwrite);
      if (take || ev != ev_reg) begin
        quiet_reg <= 5'h0;
      end else if (quiet_reg != 5'h1f) begin
        quiet_reg <= quiet_reg + 5'h1;
      end
    end
  end
  default clocking dirq_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_fall_b;
    $fell(request_line_b) |-> $past(take && hwrite, 2) || $past(take && hwrite, 3);
  endproperty
  a_fall_b: assert property (p_fall_b) else $error("request b dropped without a write");
  property p_rdata;
    !$past(take && !hwrite) |-> $stable(hrdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without a read");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_rise_b;
    $rose(request_line_b) |-> quiet_reg < 5'h10;
  endproperty
  a_rise_b: assert property (p_rise_b) else $error("request b rose with no cause");
  property p_gpio;
    $changed(gpio_out) |-> quiet_reg < 5'h10;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pin output moved with no cause");
  property p_pin_a;
    $changed(request_line_a_pin) |-> quiet_reg < 5'h10;
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("request a moved with no cause");
  property p_masked;
    !written_reg |-> !request_line_b && request_line_a_pin;
  endproperty
  a_masked: assert property (p_masked) else $error("request raised while all masked");
  property p_freeze;
    !clk_en |=> $stable(request_line_b) && $stable(request_line_a_pin) && $stable(gpio_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  c_rise: cover property ($rose(request_line_b));
  c_fall: cover property ($fell(request_line_b));
  c_pin: cover property ($changed(gpio_out));
endmodule // dirq_checker
bind dirq_controller dirq_checker #(.NPIN(NPIN), .NSUB_MAIN(NSUB_MAIN), .NSUB_SECOND(NSUB_SECOND)) dirq_checker_i (
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .short_main_sub(short_main_sub),
  .short_second_sub(short_second_sub), .excess_sub(excess_sub), .mixer_drop(mixer_drop), .port_error(port_error),
  .jack_sense_one(jack_sense_one), .gpio_in(gpio_in), .core_processor_flags(core_processor_flags),
  .request_line_a_pin(request_line_a_pin), .request_line_b(request_line_b), .gpio_out(gpio_out));

/* dv/dirq_controller_test.sv */
module dirq_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0, mixer_drop = 1'b0;
  logic jack_sense_one = 1'b0;
  logic [1:0] htrans = 2'h0, excess_sub = 2'h0, core_processor_flags = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata;
  logic [3:0] short_main_sub = 4'h0, short_second_sub = 4'h0;
  logic [2:0] port_error = 3'h0;
  logic [5:0] gpio_in = 6'h0;
  wire hready, hresp, request_line_a_pin, request_line_b;
  wire [31:0] hrdata;
  wire [5:0] gpio_out;
  wire [7:0] raises;
  int failures = 0, checked = 0;
  dirq_controller #(.DEB_W(2)) dirq_controller_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .short_main_sub(short_main_sub),
    .short_second_sub(short_second_sub), .excess_sub(excess_sub), .mixer_drop(mixer_drop), .port_error(port_error),
    .jack_sense_one(jack_sense_one), .gpio_in(gpio_in), .core_processor_flags(core_processor_flags),
    .request_line_a_pin(request_line_a_pin), .request_line_b(request_line_b), .gpio_out(gpio_out));
  dirq_host_watch dirq_host_watch_i (.hclk(hclk), .hresetn(hresetn), .req(request_line_b), .raises(raises));
  always #25 hclk = ~hclk;
  task automatic conclude;
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic probe(input int k);
    return k == 0 ? request_line_b : k == 1 ? gpio_out[0] : request_line_a_pin;
  endfunction
  task automatic wait_for(input int k, input logic v);
    for (int n = 0; n < 64 && probe(k) !== v; n++) @(posedge hclk);
    chk({31'h0, probe(k)}, {31'h0, v});
    if (probe(k) !== v) conclude();
  endtask
  task automatic hold;
    @(posedge hclk);
    for (int n = 0; hready !== 1'b1; n++) begin
      if (n > 16) chk(32'h0, 32'h1);
      if (n > 16) conclude();
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold();
    rdata = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic ev_b(input logic [31:0] exp);
    wait_for(0, 1'b1);
    rd(32'h04, exp);
    wr(32'h04, exp);
    wait_for(0, 1'b0);
  endtask
  task automatic drive(input int s, input logic v);
    case (s)
      0: short_main_sub[0] <= v;
      1: short_second_sub[3] <= v;
      2: mixer_drop <= v;
      6: excess_sub[1] <= v;
      default: port_error[s-3] <= v;
    endcase
  endtask
  task automatic t_port;
    wr(32'h08, 32'hfffffff7);
    wr(32'h0c, 32'hfffffff7);
    wr(32'h18, 32'h4);
    port_error <= 3'h1;
    wait_for(0, 1'b1);
    rd(32'h20, 32'h3);
    rd(32'h00, 32'h8);
    ev_b(32'h8);
    chk({31'h0, request_line_a_pin}, 32'h0);
    wr(32'h18, 32'h0);
    wait_for(2, 1'b1);
    wr(32'h18, 32'h1);
    rd(32'h20, 32'h0);
    port_error <= 3'h0;
    ev_b(32'h8);
    wr(32'h00, 32'h8);
  endtask
  task automatic t_misc;
    wr(32'h0c, 32'hffffff3e);
    jack_sense_one <= 1'b1;
    ev_b(32'h40);
    jack_sense_one <= 1'b0;
    ev_b(32'h80);
    short_second_sub <= 4'h8;
    ev_b(32'h1);
    rd(32'h14, 32'h80);
    short_second_sub <= 4'h0;
    repeat (12) @(posedge hclk);
    chk({31'h0, request_line_b}, 32'h0);
    wr(32'h24, 32'h1);
    wr(32'h0c, 32'hfffffbff);
    gpio_in[0] <= 1'b1;
    @(posedge hclk);
    gpio_in[0] <= 1'b0;
    repeat (12) @(posedge hclk);
    chk({31'h0, request_line_b}, 32'h0);
    gpio_in[0] <= 1'b1;
    ev_b(32'h400);
    gpio_in[0] <= 1'b0;
    ev_b(32'h400);
    wr(32'h0c, 32'hffffffff);
  endtask
  task automatic t_pins;
    logic [5:0] code [9] = '{6'h0a, 6'h0b, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2d, 6'h2d, 6'h2e};
    int src [9] = '{0, 1, 2, 3, 4, 5, 0, 1, 6};
    for (int i = 0; i < 9; i++) begin
      wr(32'h1c, {26'h0, code[i]});
      drive(src[i], 1'b1);
      wait_for(1, 1'b1);
      drive(src[i], 1'b0);
      wait_for(1, 1'b0);
    end
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    chk({30'h0, request_line_b, request_line_a_pin}, 32'h1);
    rd(32'h18, 32'h7);
    rd(32'h04, 32'h0);
    wr(32'h28, 32'hffffffff);
    rd(32'h28, 32'h0);
    t_port();
    t_misc();
    t_pins();
    clk_en <= 1'b0;
    repeat (3) @(posedge hclk);
    clk_en <= 1'b1;
    chk({24'h0, raises}, 32'h7);
    conclude();
  end
endmodule // dirq_controller_test

/* dv/dirq_host_watch.sv */
module dirq_host_watch (
  input wire hclk,
  input wire hresetn,
  input wire req,
  output logic [7:0] raises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= 1'b0;
      raises <= 8'h0;
    end else begin
      req_reg <= req;
      raises <= raises + {7'h0, req && !req_reg};
    end
  end
endmodule // dirq_host_watch

/* logic/dirq_consts.vh */
`ifndef DIRQ_CONSTS_VH
`define DIRQ_CONSTS_VH
// Register byte offsets.
`define DIRQ_OFS_FLAG_A 8'h00
`define DIRQ_OFS_FLAG_B 8'h04
`define DIRQ_OFS_MASK_A 8'h08
`define DIRQ_OFS_MASK_B 8'h0c
`define DIRQ_OFS_RAW 8'h10
`define DIRQ_OFS_SUB 8'h14
`define DIRQ_OFS_CTRL 8'h18
`define DIRQ_OFS_PINSEL 8'h1c
`define DIRQ_OFS_STATUS 8'h20
`define DIRQ_OFS_DEBEN 8'h24
// Field positions in the control register.
`define DIRQ_CTRL_GMASK_A 0
`define DIRQ_CTRL_GMASK_B 1
`define DIRQ_CTRL_POL 2
// Control register reset value: both global masks set, polarity active low.
`define DIRQ_CTRL_RST 3'h7
// Event vector positions.
`define DIRQ_EV_SHORT 0
`define DIRQ_EV_EXCESS 1
`define DIRQ_EV_DROP 2
`define DIRQ_EV_PORT0 3
`define DIRQ_EV_JACK_R 6
`define DIRQ_EV_JACK_F 7
`define DIRQ_EV_GP5_R 8
`define DIRQ_EV_GP5_F 9
`define DIRQ_EV_GPIO0 10
`define DIRQ_EV_DSP0 16
`define DIRQ_NEV 18
// Pin function codes.
`define DIRQ_FN_SHORT_MAIN 6'h0a
`define DIRQ_FN_SHORT_SECOND 6'h0b
`define DIRQ_FN_DROP 6'h27
`define DIRQ_FN_PORT0 6'h28
`define DIRQ_FN_PORT1 6'h29
`define DIRQ_FN_PORT2 6'h2a
`define DIRQ_FN_SHORT_ALL 6'h2d
`define DIRQ_FN_EXCESS 6'h2e
`define DIRQ_FN_REQ_A 6'h01
`define DIRQ_FN_REQ_B 6'h02
`define DIRQ_FN_W 6
// AHB transfer type and response.
`define DIRQ_HTRANS_NONSEQ 2'h2
`define DIRQ_HRESP_OKAY 1'h0
`endif

/* logic/dirq_controller.v */
// Summary of operation
// R1 - Function 0Ah drives pin high while main clock is short of cycles.
// R2 - Function 0Bh drives pin high while second clock is short of cycles.
// R3 - Function 27h shows mixer dropped-sample error on the pin.
// R4 - Function 2Dh shows OR of all shortfall sources in both domains.
// R5 - Function 2Eh shows clock-excess error.
// R6 - Rate converters and serial ports feed combined shortfall, no own bits.
// R7 - Three serial port errors appear on functions 28h, 29h, 2Ah.
// R8 - Serial port errors set their flag on both edges.
// R9 - Serial port errors routable to any pin by its function select; pin five here takes only codes 00h to 03h.
// R10 - Two independent flag sets, each with its own request line.
// R11 - One flag per input per set, set on its edge kind.
// R12 - Jack sense one and gpio five have separate rise and fall flags.
// R13 - Raw status register reads present input levels.
// R14 - Shortfall and excess are ORs; each sub flag is readable.
// R15 - Masked input sets no flag and raises no request.
// R16 - Each request line is OR of its own flag set.
// R17 - Flags latch until host writes one to the bit.
// R18 - Request holds until every associated flag is cleared.
// R19 - Per-pin enable inserts debounce filter on gpio inputs.
// R20 - Host may read flags at any time.
// R21 - Global mask per request; unmasked state readable in status; status here reads req_a and req_b after the global mask.
// R22 - Line a on dedicated pin, active low by default, polarity bit inverts.
// R23 - Edges found by comparing sample with previous cycle, one-cycle pulse.
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`include "dirq_consts.vh"
module dirq_controller #(
  parameter NPIN = 6,
  parameter NSUB_MAIN = 4,
  parameter NSUB_SECOND = 4,
  parameter DEB_W = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [NSUB_MAIN-1:0] short_main_sub,
  input wire [NSUB_SECOND-1:0] short_second_sub,
  input wire [1:0] excess_sub,
  input wire mixer_drop,
  input wire [2:0] port_error,
  input wire jack_sense_one,
  input wire [NPIN-1:0] gpio_in,
  input wire [1:0] core_processor_flags,
  output reg request_line_a_pin,
  output reg request_line_b,
  output reg [NPIN-1:0] gpio_out
);
  localparam NSUB = NSUB_MAIN + NSUB_SECOND + 2;
  localparam NRAW = 6 + 1 + NPIN + 2;
  // Two-stage synchronisers for all asynchronous inputs.
  reg [NSUB-1:0] sub_s1_reg, sub_s2_reg;
  reg [NRAW-1:0] raw_s1_reg, raw_s2_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_s1_reg <= {NSUB{1'b0}};
      sub_s2_reg <= {NSUB{1'b0}};
      raw_s1_reg <= {NRAW{1'b0}};
      raw_s2_reg <= {NRAW{1'b0}};
    end else if (clk_en) begin
      sub_s1_reg <= {excess_sub, short_second_sub, short_main_sub};
      sub_s2_reg <= sub_s1_reg;
      raw_s1_reg <= {core_processor_flags, gpio_in, jack_sense_one, port_error, 1'b0, 1'b0, mixer_drop};
      raw_s2_reg <= raw_s1_reg;
    end
  end
  wire [NSUB_MAIN-1:0] sm = sub_s2_reg[NSUB_MAIN-1:0];
  wire [NSUB_SECOND-1:0] ss = sub_s2_reg[NSUB_MAIN+NSUB_SECOND-1:NSUB_MAIN];
  wire [1:0] sx = sub_s2_reg[NSUB-1:NSUB-2];
  wire short_main = |sm; // R1 R6
  wire short_second = |ss; // R2 R6
  wire short_all = short_main | short_second; // R4 R14
  wire excess = |sx; // R5 R14
  // Debounced gpio levels.
  reg [NPIN-1:0] deben_reg;
  wire [NPIN-1:0] gpio_clean;
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_deb
      dirq_debounce #(.CNT_W(DEB_W)) u_deb (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .enable(deben_reg[gi]), // R19
        .din(raw_s2_reg[7+gi]),
        .dout(gpio_clean[gi])
      );
    end
  endgenerate
  // Present levels of every event source; shortfall and excess enter as their ORs.
  wire [`DIRQ_NEV-1:0] level;
  // Jack sense and gpio five each fill a rise slot and a fall slot.
  assign level = {raw_s2_reg[NRAW-1:NRAW-2], gpio_clean, gpio_clean[5], gpio_clean[5], raw_s2_reg[6], raw_s2_reg[6],
    raw_s2_reg[5:3], raw_s2_reg[0], excess, short_all};
  reg [`DIRQ_NEV-1:0] level_prev_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_prev_reg <= {`DIRQ_NEV{1'b0}};
    end else if (clk_en) begin
      level_prev_reg <= level; // R23
    end
  end
  wire [`DIRQ_NEV-1:0] rise = level & ~level_prev_reg;
  wire [`DIRQ_NEV-1:0] fall = ~level & level_prev_reg;
  wire [`DIRQ_NEV-1:0] both = rise | fall;
  reg [`DIRQ_NEV-1:0] event_pulse;
  always @* begin
    event_pulse = both; // R8 R11
    event_pulse[`DIRQ_EV_SHORT] = rise[`DIRQ_EV_SHORT]; // R11
    event_pulse[`DIRQ_EV_EXCESS] = rise[`DIRQ_EV_EXCESS];
    event_pulse[`DIRQ_EV_DROP] = rise[`DIRQ_EV_DROP];
    event_pulse[`DIRQ_EV_JACK_R] = rise[`DIRQ_EV_JACK_R]; // R12
    event_pulse[`DIRQ_EV_JACK_F] = fall[`DIRQ_EV_JACK_R];
    event_pulse[`DIRQ_EV_GP5_R] = rise[`DIRQ_EV_GPIO0+5];
    event_pulse[`DIRQ_EV_GP5_F] = fall[`DIRQ_EV_GPIO0+5];
  end
  // AHB-Lite slave: address phase captured, data phase in next cycle, zero wait.
  reg wr_pend_reg, rd_pend_reg;
  reg [7:0] addr_reg;
  wire take = hsel & hready & htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else if (clk_en) begin
      wr_pend_reg <= take & hwrite;
      rd_pend_reg <= take & ~hwrite;
      if (take) begin
        addr_reg <= haddr[7:0];
      end
    end
  end
  wire wr_ok = wr_pend_reg & clk_en;
  wire [`DIRQ_NEV-1:0] clr_a = (wr_ok && addr_reg == `DIRQ_OFS_FLAG_A) ? hwdata[`DIRQ_NEV-1:0] : {`DIRQ_NEV{1'b0}};
  wire [`DIRQ_NEV-1:0] clr_b = (wr_ok && addr_reg == `DIRQ_OFS_FLAG_B) ? hwdata[`DIRQ_NEV-1:0] : {`DIRQ_NEV{1'b0}};
  reg [`DIRQ_NEV-1:0] flag_a_reg, flag_b_reg, mask_a_reg, mask_b_reg;
  reg [2:0] ctrl_reg;
  reg [NPIN*`DIRQ_FN_W-1:0] pinsel_reg;
  // The select fields are wider than one bus word; select bits beyond the word stay zero.
  wire [63:0] hwdata_ext = {32'h00000000, hwdata};
  wire [63:0] pinsel_ext = {{(64-NPIN*`DIRQ_FN_W){1'b0}}, pinsel_reg};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_a_reg <= {`DIRQ_NEV{1'b0}};
      flag_b_reg <= {`DIRQ_NEV{1'b0}};
      mask_a_reg <= {`DIRQ_NEV{1'b1}};
      mask_b_reg <= {`DIRQ_NEV{1'b1}};
      ctrl_reg <= `DIRQ_CTRL_RST;
      pinsel_reg <= {(NPIN*`DIRQ_FN_W){1'b0}};
      deben_reg <= {NPIN{1'b0}};
    end else if (clk_en) begin
      flag_a_reg <= (flag_a_reg & ~clr_a) | (event_pulse & ~mask_a_reg); // R10 R15 R17
      flag_b_reg <= (flag_b_reg & ~clr_b) | (event_pulse & ~mask_b_reg); // R10 R15 R17
      if (wr_ok && addr_reg == `DIRQ_OFS_MASK_A) begin
        mask_a_reg <= hwdata[`DIRQ_NEV-1:0];
      end
      if (wr_ok && addr_reg == `DIRQ_OFS_MASK_B) begin
        mask_b_reg <= hwdata[`DIRQ_NEV-1:0];
      end
      if (wr_ok && addr_reg == `DIRQ_OFS_CTRL) begin
        ctrl_reg <= hwdata[2:0];
      end
      if (wr_ok && addr_reg == `DIRQ_OFS_PINSEL) begin
        pinsel_reg <= hwdata_ext[NPIN*`DIRQ_FN_W-1:0];
      end
      if (wr_ok && addr_reg == `DIRQ_OFS_DEBEN) begin
        deben_reg <= hwdata[NPIN-1:0];
      end
    end
  end
  // Request lines: OR of the set, gated by the global mask.
  wire req_a = (|flag_a_reg) & ~ctrl_reg[`DIRQ_CTRL_GMASK_A]; // R16 R18 R21
  wire req_b = (|flag_b_reg) & ~ctrl_reg[`DIRQ_CTRL_GMASK_B]; // R16 R18 R21
  // Pin function mux.
  reg [NPIN-1:0] gpio_next;
  integer pi;
  always @* begin
    gpio_next = {NPIN{1'b0}};
    for (pi = 0; pi < NPIN; pi = pi + 1) begin
      case (pinsel_reg[pi*`DIRQ_FN_W +: `DIRQ_FN_W])
        `DIRQ_FN_SHORT_MAIN: gpio_next[pi] = short_main; // R1
        `DIRQ_FN_SHORT_SECOND: gpio_next[pi] = short_second; // R2
        `DIRQ_FN_DROP: gpio_next[pi] = raw_s2_reg[0]; // R3
        `DIRQ_FN_PORT0: gpio_next[pi] = raw_s2_reg[3]; // R7 R9
        `DIRQ_FN_PORT1: gpio_next[pi] = raw_s2_reg[4]; // R7 R9
        `DIRQ_FN_PORT2: gpio_next[pi] = raw_s2_reg[5]; // R7 R9
        `DIRQ_FN_SHORT_ALL: gpio_next[pi] = short_all; // R4
        `DIRQ_FN_EXCESS: gpio_next[pi] = excess; // R5
        `DIRQ_FN_REQ_A: gpio_next[pi] = req_a;
        `DIRQ_FN_REQ_B: gpio_next[pi] = req_b;
        default: gpio_next[pi] = 1'b0;
      endcase
    end
  end
  // Read mux.
  reg [31:0] rdata_next;
  always @* begin
    rdata_next = 32'h00000000;
    case (haddr[7:0])
      `DIRQ_OFS_FLAG_A: rdata_next[`DIRQ_NEV-1:0] = flag_a_reg; // R20
      `DIRQ_OFS_FLAG_B: rdata_next[`DIRQ_NEV-1:0] = flag_b_reg; // R20
      `DIRQ_OFS_MASK_A: rdata_next[`DIRQ_NEV-1:0] = mask_a_reg;
      `DIRQ_OFS_MASK_B: rdata_next[`DIRQ_NEV-1:0] = mask_b_reg;
      `DIRQ_OFS_RAW: rdata_next[`DIRQ_NEV-1:0] = level; // R13
      `DIRQ_OFS_SUB: rdata_next[NSUB-1:0] = sub_s2_reg; // R14
      `DIRQ_OFS_CTRL: rdata_next[2:0] = ctrl_reg;
      `DIRQ_OFS_PINSEL: rdata_next = pinsel_ext[31:0];
      `DIRQ_OFS_STATUS: rdata_next[1:0] = {req_b, req_a}; // R21
      `DIRQ_OFS_DEBEN: rdata_next[NPIN-1:0] = deben_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= `DIRQ_HRESP_OKAY;
      request_line_a_pin <= 1'b1;
      request_line_b <= 1'b0;
      gpio_out <= {NPIN{1'b0}};
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= `DIRQ_HRESP_OKAY;
      if (take && !hwrite) begin
        hrdata <= rdata_next;
      end
      request_line_a_pin <= req_a ^ ctrl_reg[`DIRQ_CTRL_POL]; // R22
      request_line_b <= req_b;
      gpio_out <= gpio_next;
    end
  end
endmodule // dirq_controller

/* logic/dirq_debounce.v */
module dirq_debounce #(
  parameter CNT_W = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire enable,
  input wire din,
  output reg dout
);
  reg [CNT_W-1:0] cnt_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= {CNT_W{1'b0}};
      dout <= 1'b0;
    end else if (clk_en) begin
      if (!enable || din == dout) begin
        cnt_reg <= {CNT_W{1'b0}};
        if (!enable) begin
          dout <= din;
        end
      end else if (&cnt_reg) begin
        dout <= din;
        cnt_reg <= {CNT_W{1'b0}};
      end else begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // dirq_debounce
